/* logic/adc_seq_defines.vh */
// register offsets, field positions, reset values and timing counts of the sequencer
`ifndef ADC_SEQ_DEFINES_VH
`define ADC_SEQ_DEFINES_VH
`define OFS_CTRL_MAIN 16'hFFBE
`define OFS_TIMING_STD 16'hF09E
`define OFS_TIMING_INJ 16'hF0A2
`define OFS_RESULT 16'hF0A0
`define CTRL_MAIN_RESET 16'h1000
`define TIMING_RESET 16'h0000
`define RESULT_RESET 16'h0000
`define CTRL_RW_MASK 16'hBEFF
`define TIMING_RW_MASK 16'h3FFF
`define BIT_LAYOUT 15
`define BIT_SAMPLE 14
`define BIT_INJ_TRG_HI 13
`define BIT_INJ_TRG_LO 12
`define BIT_INJ_REQ 11
`define BIT_INJ_EN 10
`define BIT_WAIT_RD 9
`define BIT_BUSY 8
`define BIT_RUN 7
`define BIT_PAT_HI 6
`define BIT_PAT_LO 5
`define BIT_CAL_OFF 4
`define BIT_CH_HI 3
`define BIT_CH_LO 0
`define BIT_WIDTH_HI 13
`define BIT_WIDTH_LO 12
`define BIT_DIV_HI 11
`define BIT_DIV_LO 6
`define BIT_STIME_HI 5
`define BIT_STIME_LO 0
`define SAMPLE_MULT 9'h004
`define SAMPLE_ADD 9'h002
`define CONV_BC_10 9'h00A
`define CONV_BC_8 9'h008
`define CAL_BC 9'h004
`define WIDTH_10 2'h0
`define WIDTH_8 2'h1
`endif

/* logic/adc_enhanced_mode_sequencer.v */
// control and sequencing logic of the converter in its enhanced register layout
`include "adc_seq_defines.vh"
`default_nettype none
module adc_enhanced_mode_sequencer (
    input wire CLK_SYS,
    input wire RESET,
    input wire [15:0] ADDR,
    input wire [15:0] WDATA,
    input wire WR,
    input wire RD,
    output reg [15:0] RDATA,
    input wire [9:0] CORE_RESULT,
    output reg [3:0] MUX_CHANNEL,
    output reg SAMPLE_HOLD,
    output reg CONV_DONE_IRQ,
    output reg [1:0] INJ_TRIGGER_SRC,
    output reg LAYOUT_ENHANCED
);

    localparam [3:0] ST_IDLE = 4'h1;
    localparam [3:0] ST_CAL = 4'h2;
    localparam [3:0] ST_SAMPLE = 4'h4;
    localparam [3:0] ST_CONV = 4'h8;

    reg [15:0] ctrl_q;
    reg [15:0] tim_std_q;
    reg [15:0] tim_inj_q;
    reg [15:0] result_q;
    reg [3:0] state_q;
    reg [5:0] div_cnt_q;
    reg [8:0] bc_cnt_q;
    reg [3:0] chan_q;
    reg [1:0] pat_q;
    reg stop_req_q;
    reg [3:0] state_d;
    reg [8:0] bc_cnt_d;
    reg [3:0] chan_d;
    reg [1:0] pat_d;
    reg stop_req_d;
    wire [9:0] core_sync;

    // one-hot register select, shared by write and read decode
    function [3:0] reg_select;
        input [15:0] a;
        begin
            case (a)
                `OFS_CTRL_MAIN: reg_select = 4'h1;
                `OFS_TIMING_STD: reg_select = 4'h2;
                `OFS_TIMING_INJ: reg_select = 4'h4;
                `OFS_RESULT: reg_select = 4'h8;
                default: reg_select = 4'h0;
            endcase
        end
    endfunction

    wire [3:0] addr_sel = reg_select(ADDR);
    wire wr_ctrl = WR && addr_sel[0];
    wire wr_tim_std = WR && addr_sel[1];
    wire wr_tim_inj = WR && addr_sel[2];
    wire new_run = WDATA[`BIT_RUN];
    wire run_q = ctrl_q[`BIT_RUN];
    wire [1:0] width_sel = tim_std_q[`BIT_WIDTH_HI:`BIT_WIDTH_LO];
    wire [5:0] div_sel = tim_std_q[`BIT_DIV_HI:`BIT_DIV_LO];
    wire [5:0] stime_sel = tim_std_q[`BIT_STIME_HI:`BIT_STIME_LO];
    wire bc_tick = (div_cnt_q == div_sel);
    // phase lengths in basic clocks; the product never exceeds nine bits
    wire [8:0] stime_ext = {3'h0, stime_sel};
    wire [17:0] sample_prod = `SAMPLE_MULT * (stime_ext + `SAMPLE_ADD);
    wire [8:0] sample_len = sample_prod[8:0];
    // reserved widths run as ten bit, nothing else changes
    wire [8:0] conv_len = (width_sel == `WIDTH_8) ? `CONV_BC_8 : `CONV_BC_10;
    wire [8:0] cal_len = `CAL_BC;
    wire phase_end = bc_tick && (bc_cnt_q == 9'h001);
    wire conv_end = (state_q == ST_CONV) && phase_end;
    wire scan_mode = pat_q[1];
    wire cont_mode = pat_q[0];
    wire seq_last = scan_mode ? (chan_q == 4'h0) : 1'b1;
    wire in_sample = (state_q == ST_SAMPLE);
    wire busy_now = (state_q != ST_IDLE);
    // restart when run goes 0 then 1; a plain rewrite of 1 while running is harmless
    wire start_req = wr_ctrl && new_run && (!run_q || stop_req_q);
    // an aborting restart in the same cycle drops the result
    wire conv_done = conv_end && !start_req;
    // single patterns drop the run bit as the last channel completes
    wire hw_run_clear = conv_done && seq_last && !cont_mode;

    function [15:0] result_word;
        input [9:0] raw;
        input [1:0] wsel;
        input [3:0] ch;
        begin
            if (wsel == `WIDTH_8) begin
                result_word = {ch, raw[9:2], 4'h0};
            end else begin
                result_word = {ch, raw, 2'h0};
            end
        end
    endfunction

    // live status bits replace the stored copies on every read
    function [15:0] ctrl_view;
        input [15:0] stored;
        input sampling;
        input busy;
        begin
            ctrl_view = stored;
            ctrl_view[`BIT_SAMPLE] = sampling;
            ctrl_view[`BIT_BUSY] = busy;
        end
    endfunction

    // reserved code maps to no source, so it can never trigger
    function [1:0] trig_source;
        input [1:0] sel;
        begin
            case (sel)
                2'h1: trig_source = 2'h1;
                2'h2: trig_source = 2'h2;
                default: trig_source = 2'h0;
            endcase
        end
    endfunction

    // core result arrives from the analog side, two flops per bit
    genvar gi;
    generate
        for (gi = 0; gi < 10; gi = gi + 1) begin : core_sync_bit
            reg s1_q;
            reg s2_q;
            always @(posedge CLK_SYS) begin
                if (RESET) begin
                    s1_q <= 1'b0;
                    s2_q <= 1'b0;
                end else begin
                    s1_q <= CORE_RESULT[gi];
                    s2_q <= s1_q;
                end
            end
            assign core_sync[gi] = s2_q;
        end
    endgenerate

    always @(posedge CLK_SYS) begin
        if (RESET) begin
            div_cnt_q <= 6'h00;
        // restarting with each start keeps phases aligned to the write
        end else if (state_q == ST_IDLE || bc_tick || start_req) begin
            div_cnt_q <= 6'h00;
        end else begin
            div_cnt_q <= div_cnt_q + 6'h01;
        end
    end

    // sequencer next state; a start overrides whatever phase is running
    always @* begin
        state_d = state_q;
        bc_cnt_d = bc_cnt_q;
        chan_d = chan_q;
        pat_d = pat_q;
        stop_req_d = stop_req_q;
        if (start_req) begin
            // fresh start uses values being written right now
            pat_d = WDATA[`BIT_PAT_HI:`BIT_PAT_LO];
            chan_d = WDATA[`BIT_CH_HI:`BIT_CH_LO];
            stop_req_d = 1'b0;
            if (!WDATA[`BIT_CAL_OFF]) begin
                state_d = ST_CAL;
                bc_cnt_d = cal_len;
            end else begin
                state_d = ST_SAMPLE;
                bc_cnt_d = sample_len;
            end
        end else begin
            if (wr_ctrl && !new_run && state_q != ST_IDLE) begin
                stop_req_d = 1'b1;
            end
            case (state_q)
                ST_IDLE: begin
                    stop_req_d = 1'b0;
                end
                ST_CAL: begin
                    if (bc_tick) begin
                        bc_cnt_d = bc_cnt_q - 9'h001;
                    end
                    if (phase_end) begin
                        state_d = ST_SAMPLE;
                        bc_cnt_d = sample_len;
                    end
                end
                ST_SAMPLE: begin
                    if (bc_tick) begin
                        bc_cnt_d = bc_cnt_q - 9'h001;
                    end
                    if (phase_end) begin
                        state_d = ST_CONV;
                        bc_cnt_d = conv_len;
                    end
                end
                ST_CONV: begin
                    if (bc_tick) begin
                        bc_cnt_d = bc_cnt_q - 9'h001;
                    end
                    if (phase_end) begin
                        // pattern is looked at again after every conversion
                        pat_d = ctrl_q[`BIT_PAT_HI:`BIT_PAT_LO];
                        if (seq_last && (!cont_mode || stop_req_q || !run_q)) begin
                            state_d = ST_IDLE;
                        end else begin
                            state_d = ST_SAMPLE;
                            bc_cnt_d = sample_len;
                            if (scan_mode && !seq_last) begin
                                chan_d = chan_q - 4'h1;
                            end else begin
                                chan_d = ctrl_q[`BIT_CH_HI:`BIT_CH_LO];
                            end
                        end
                    end
                end
                default: begin
                    state_d = ST_IDLE;
                end
            endcase
        end
    end

    always @(posedge CLK_SYS) begin
        if (RESET) begin
            state_q <= ST_IDLE;
            bc_cnt_q <= 9'h000;
            chan_q <= 4'h0;
            pat_q <= 2'h0;
            stop_req_q <= 1'b0;
        end else begin
            state_q <= state_d;
            bc_cnt_q <= bc_cnt_d;
            chan_q <= chan_d;
            pat_q <= pat_d;
            stop_req_q <= stop_req_d;
        end
    end

    // control register; hardware clear of run wins only at sequence end
    always @(posedge CLK_SYS) begin
        if (RESET) begin
            ctrl_q <= `CTRL_MAIN_RESET;
        end else begin
            if (wr_ctrl) begin
                ctrl_q <= (WDATA & `CTRL_RW_MASK) | (ctrl_q & ~`CTRL_RW_MASK);
                // injection request: set by software only, and sticky: once set, later writes cannot clear it
                if (ctrl_q[`BIT_INJ_REQ]) begin
                    ctrl_q[`BIT_INJ_REQ] <= 1'b1;
                end
            end
            if (hw_run_clear) begin
                ctrl_q[`BIT_RUN] <= 1'b0;
            end
            ctrl_q[`BIT_SAMPLE] <= 1'b0;
            ctrl_q[`BIT_BUSY] <= 1'b0;
        end
    end

    // injected timing is only stored; no injected conversion runs here
    always @(posedge CLK_SYS) begin
        if (RESET) begin
            tim_std_q <= `TIMING_RESET;
            tim_inj_q <= `TIMING_RESET;
        end else begin
            if (wr_tim_std) begin
                tim_std_q <= WDATA & `TIMING_RW_MASK;
            end
            if (wr_tim_inj) begin
                tim_inj_q <= WDATA & `TIMING_RW_MASK;
            end
        end
    end

    always @(posedge CLK_SYS) begin
        if (RESET) begin
            result_q <= `RESULT_RESET;
        end else if (conv_done) begin
            result_q <= result_word(core_sync, width_sel, chan_q);
        end
    end

    always @(posedge CLK_SYS) begin
        if (RESET) begin
            CONV_DONE_IRQ <= 1'b0;
        end else begin
            CONV_DONE_IRQ <= conv_done;
        end
    end

    // channel and hold follow the sequencer one cycle late
    always @(posedge CLK_SYS) begin
        if (RESET) begin
            MUX_CHANNEL <= 4'h0;
            SAMPLE_HOLD <= 1'b0;
        end else begin
            MUX_CHANNEL <= chan_q;
            SAMPLE_HOLD <= (state_q == ST_CONV);
        end
    end

    always @(posedge CLK_SYS) begin
        if (RESET) begin
            INJ_TRIGGER_SRC <= 2'h0;
            LAYOUT_ENHANCED <= 1'b0;
        end else begin
            INJ_TRIGGER_SRC <= trig_source(ctrl_q[`BIT_INJ_TRG_HI:`BIT_INJ_TRG_LO]);
            LAYOUT_ENHANCED <= ctrl_q[`BIT_LAYOUT];
        end
    end

    // read data stand for one cycle only, zero otherwise
    always @(posedge CLK_SYS) begin
        if (RESET) begin
            RDATA <= 16'h0000;
        end else if (RD) begin
            case (addr_sel)
                4'h1: begin
                    RDATA <= ctrl_view(ctrl_q, in_sample, busy_now);
                end
                4'h2: begin
                    RDATA <= tim_std_q;
                end
                4'h4: begin
                    RDATA <= tim_inj_q;
                end
                4'h8: begin
                    RDATA <= result_q;
                end
                default: begin
                    RDATA <= 16'h0000;
                end
            endcase
        end else begin
            RDATA <= 16'h0000;
        end
    end

endmodule // adc_enhanced_mode_sequencer
`default_nettype wire

/* dv/adc_seq_checker.sv */
// port checks of the converter sequencer, bound into the design
`include "adc_seq_defines.vh"
`default_nettype none
module adc_seq_checker (
    input wire logic CLK_SYS,
    input wire logic RESET,
    input wire logic [15:0] ADDR,
    input wire logic [15:0] WDATA,
    input wire logic WR,
    input wire logic [3:0] MUX_CHANNEL,
    input wire logic SAMPLE_HOLD,
    input wire logic CONV_DONE_IRQ,
    input wire logic [1:0] INJ_TRIGGER_SRC,
    input wire logic LAYOUT_ENHANCED
);
timeunit 1ns;
timeprecision 1ps;
default clocking cb @(posedge CLK_SYS); endclocking
default disable iff (RESET);
sequence ctrl_wr;
    WR && ADDR == `OFS_CTRL_MAIN;
endsequence
sequence quiet3;
    !WR [*3];
endsequence
property trig_map;
    logic [1:0] v;
    (ctrl_wr, v = WDATA[13:12]) ##1 quiet3 |-> INJ_TRIGGER_SRC == (v == 2'h3 ? 2'h0 : v);
endproperty
property layout_map;
    logic l;
    (ctrl_wr, l = WDATA[15]) ##1 quiet3 |-> LAYOUT_ENHANCED == l;
endproperty
trig_map_a: assert property (trig_map) else $error("trigger source wrong");
trig_resv_a: assert property (INJ_TRIGGER_SRC != 2'h3) else $error("reserved trigger");
layout_map_a: assert property (layout_map) else $error("layout output wrong");
hold_min_a: assert property ($rose(SAMPLE_HOLD) |-> SAMPLE_HOLD [*8])
    else $error("hold too short");
// a new level is sampled for at least eight cycles before the next hold
hold_gap_a: assert property ($fell(SAMPLE_HOLD) |-> !SAMPLE_HOLD [*8])
    else $error("sample phase too short");
chan_still_a: assert property (SAMPLE_HOLD && $past(SAMPLE_HOLD) && $past(SAMPLE_HOLD, 2)
    |-> $past(MUX_CHANNEL) == $past(MUX_CHANNEL, 2)) else $error("channel moved in hold");
irq_hold_a: assert property (CONV_DONE_IRQ |-> $past(SAMPLE_HOLD) || $past(SAMPLE_HOLD, 2))
    else $error("irq without conversion");
irq_gap_a: assert property (CONV_DONE_IRQ |=> !CONV_DONE_IRQ [*8])
    else $error("irq pulses too close");
endmodule // adc_seq_checker
bind adc_enhanced_mode_sequencer adc_seq_checker chk (.CLK_SYS(CLK_SYS), .RESET(RESET),
    .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .MUX_CHANNEL(MUX_CHANNEL),
    .SAMPLE_HOLD(SAMPLE_HOLD), .CONV_DONE_IRQ(CONV_DONE_IRQ),
    .INJ_TRIGGER_SRC(INJ_TRIGGER_SRC), .LAYOUT_ENHANCED(LAYOUT_ENHANCED));
`default_nettype wire

/* dv/adc_core_model.sv */
// behavioural analog core: holds the level of the sampled channel
`default_nettype none
module adc_core_model (
    input wire logic clk,
    input wire logic [3:0] channel,
    input wire logic hold,
    output logic [9:0] level
);
timeunit 1ns;
timeprecision 1ps;
logic [3:0] ch_q;
always @(posedge clk) begin
    if (!hold) begin
        ch_q <= channel;
    end
end
// outside hold the output is inverted so a mistimed capture shows
assign level = hold ? {ch_q, ch_q, 2'h2} : ~{ch_q, ch_q, 2'h2};
endmodule // adc_core_model
`default_nettype wire

/* dv/test_adc_enhanced_mode_sequencer.sv */
// testbench of the converter sequencer with random timing
`include "adc_seq_defines.vh"
`default_nettype none
module test_adc_enhanced_mode_sequencer;
timeunit 1ns;
timeprecision 1ps;
logic CLK_SYS = 1'b0;
logic RESET = 1'b1;
logic [15:0] ADDR = 16'h0000;
logic [15:0] WDATA = 16'h0000;
logic WR = 1'b0;
logic RD = 1'b0;
wire [15:0] RDATA;
wire [9:0] CORE_RESULT;
wire [3:0] MUX_CHANNEL;
wire SAMPLE_HOLD;
wire CONV_DONE_IRQ;
wire [1:0] INJ_TRIGGER_SRC;
wire LAYOUT_ENHANCED;
int miscompares = 0;
int comparisons = 0;
int irqs = 0;
logic [15:0] tim;
logic [15:0] v;
logic [15:0] adr [5] = '{`OFS_CTRL_MAIN, `OFS_TIMING_STD, `OFS_TIMING_INJ, `OFS_RESULT, 16'h0100};
logic [15:0] rst [5] = '{`CTRL_MAIN_RESET, `TIMING_RESET, `TIMING_RESET, `RESULT_RESET, 16'h0000};
logic [15:0] ctls [6] = '{16'h8090, 16'h808F, 16'h80A3, 16'h80D3, 16'h80F2, 16'h8099};
int ns [6] = '{1, 1, 3, 4, 3, 1};
int stops [6] = '{-1, -1, 1, -1, 0, -1};
adc_enhanced_mode_sequencer uut (.CLK_SYS(CLK_SYS), .RESET(RESET), .ADDR(ADDR), .WDATA(WDATA),
    .WR(WR), .RD(RD), .RDATA(RDATA), .CORE_RESULT(CORE_RESULT), .MUX_CHANNEL(MUX_CHANNEL),
    .SAMPLE_HOLD(SAMPLE_HOLD), .CONV_DONE_IRQ(CONV_DONE_IRQ),
    .INJ_TRIGGER_SRC(INJ_TRIGGER_SRC), .LAYOUT_ENHANCED(LAYOUT_ENHANCED));
adc_core_model core (.clk(CLK_SYS), .channel(MUX_CHANNEL), .hold(SAMPLE_HOLD), .level(CORE_RESULT));
always #4 CLK_SYS = ~CLK_SYS;
always @(posedge CLK_SYS) if (CONV_DONE_IRQ === 1'b1) irqs <= irqs + 1;
task automatic print_verdict;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
endtask
task automatic check(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
        miscompares++;
        $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
endtask
task automatic bound(input int t, input int lim);
    if (t >= lim) begin
        miscompares++;
        print_verdict();
    end
endtask
// each strobe is followed by a quiet edge, so no signal is set twice in a step
task automatic wr(input logic [15:0] a, input logic [15:0] d);
    ADDR <= a;
    WDATA <= d;
    WR <= 1'b1;
    @(posedge CLK_SYS);
    WR <= 1'b0;
    @(posedge CLK_SYS);
endtask
task automatic rd(input logic [15:0] a, output logic [15:0] d);
    ADDR <= a;
    RD <= 1'b1;
    @(posedge CLK_SYS);
    RD <= 1'b0;
    #1 d = RDATA;
    @(posedge CLK_SYS);
endtask
function automatic logic [15:0] exp_res(input logic [3:0] ch, input logic [1:0] w);
    logic [9:0] f;
    f = {ch, ch, 2'h2};
    return (w == `WIDTH_8) ? {ch, f[9:2], 4'h0} : {ch, f, 2'h0};
endfunction
task automatic run(input logic [15:0] ctl, input int n, input int stop_at);
    int base;
    int t;
    logic [15:0] r;
    base = irqs;
    wr(`OFS_CTRL_MAIN, ctl);
    for (int k = 0; k < n; k++) begin
        t = 0;
        while (irqs == base + k && t < 3000) begin
            @(posedge CLK_SYS);
            t++;
        end
        bound(t, 3000);
        rd(`OFS_RESULT, r);
        check(r, exp_res(ctl[6] ? ctl[3:0] - 4'(k) : ctl[3:0], tim[13:12]));
        if (k == stop_at) begin
            rd(`OFS_CTRL_MAIN, r);
            check(r & 16'h0180, 16'h0180);
            wr(`OFS_CTRL_MAIN, ctl & 16'hFF7F);
        end
    end
    t = 0;
    do begin
        rd(`OFS_CTRL_MAIN, r);
        t++;
    end while (r[8] !== 1'b0 && t < 300);
    bound(t, 300);
    check(r & 16'h8180, 16'h8000);
    check(16'(irqs - base), 16'(n));
endtask
initial begin
    void'($urandom(18));
    repeat (8) @(posedge CLK_SYS);
    RESET <= 1'b0;
    @(posedge CLK_SYS);
    for (int i = 0; i < 5; i++) begin
        rd(adr[i], v);
        check(v, rst[i]);
    end
    for (int i = 0; i < 4; i++) begin
        wr(`OFS_CTRL_MAIN, 16'h8000 | 16'(i << 12));
        rd(`OFS_CTRL_MAIN, v);
        check(v, 16'h8000 | 16'(i << 12));
    end
    wr(`OFS_TIMING_INJ, 16'hFFFF);
    rd(`OFS_TIMING_INJ, v);
    check(v, `TIMING_RW_MASK);
    for (int s = 0; s < 6; s++) begin
        tim = {2'h0, 2'($urandom % 2), 6'($urandom % 3), 6'($urandom % 3)};
        wr(`OFS_TIMING_STD, tim);
        rd(`OFS_TIMING_STD, v);
        check(v, tim);
        if (s == 5) begin
            wr(`OFS_CTRL_MAIN, 16'h8085);
            wr(`OFS_CTRL_MAIN, 16'h8005);
        end
        run(s == 0 ? ctls[s] | 16'($urandom % 16) : ctls[s], ns[s], stops[s]);
    end
    print_verdict();
end
endmodule // test_adc_enhanced_mode_sequencer
`default_nettype wire
